// *** verilog/drc_core.sv ***
// dynamic range controller: static curve, gain limits, attack/decay slew,
// anti-clip look-ahead, quick release and activity detect
// assumes one stereo sample per in_valid, samples synchronous to clk
// assumes configuration is held steady while samples stream
`timescale 1ns/1ps
module drc_core
    import drc_pkg::*;
#(
    parameter int RATE_BASE_SHIFT = 3
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // sample stream
    input wire logic in_valid,
    input wire drc_stereo_s in_samp,
    output logic out_valid,
    output drc_stereo_s out_samp,
    // configuration
    input wire logic drc_enable,
    input wire drc_curve_s curve,
    input wire drc_dyn_s dyn,
    input wire logic activity_use_peak,
    input wire drc_lvl_t activity_threshold,
    // status
    output drc_lvl_t gain_level,
    output logic activity_detect,
    output logic fast_release_active
);
    drc_lvl_t peak_level;
    drc_lvl_t rms_level;
    logic [2*`DRC_SAMP_W-1:0] delayed_raw;
    drc_stereo_s delayed;
    logic signed [`DRC_LVL_W+8:0] target_next;
    logic signed [`DRC_LVL_W+8:0] gain_want;
    drc_region_e region_next;
    drc_region_e region_reg;
    drc_lvl_t target_reg;
    logic signed [`DRC_LVL_W+8:0] gain_acc_reg;
    logic [15:0] rate_cnt_reg;
    logic crest_high;
    logic rising_fast;
    drc_lvl_t prev_peak_reg;
    logic [`DRC_RATE_W-1:0] attack_eff;
    logic [`DRC_RATE_W-1:0] decay_eff;
    logic step_attack;
    logic step_decay;
    logic samp_d_reg;

    drc_level_det u_det (
        .clk(clk),
        .rst(rst),
        .in_valid(in_valid),
        .in_samp(in_samp),
        .peak_level(peak_level),
        .rms_level(rms_level)
    );

    drc_delay_mem #(
        .DEPTH(`DRC_ANTICLIP_LAT),
        .WIDTH(2*`DRC_SAMP_W)
    ) u_delay (
        .clk(clk),
        .rst(rst),
        .advance(in_valid),
        .wr_data(in_samp),
        .rd_data(delayed_raw)
    );
    assign delayed = drc_stereo_s'(delayed_raw);

    // slope applied to a dB distance; slope has four fraction bits
    function automatic logic signed [`DRC_LVL_W+8:0] slope_mul(input logic signed [`DRC_LVL_W+1:0] d,
                                                               input logic [5:0] s);
        logic signed [`DRC_LVL_W+8:0] p;
        p = d * $signed({1'b0, s});
        return p >>> `DRC_SLOPE_FRAC;
    endfunction

    // static curve: target output level for measured rms level
    always_comb
    begin
        logic signed [`DRC_LVL_W+8:0] knee2_curve;
        knee2_curve = curve.knee1_out_level
            + slope_mul(curve.knee2_in_level - curve.knee1_in_level, curve.lower_slope);
        region_next = DRC_REG_UPPER;
        // upper region line through knee one, with the upper slope
        target_next = curve.knee1_out_level + slope_mul(rms_level - curve.knee1_in_level, curve.upper_slope);
        if (rms_level < curve.knee1_in_level)
        begin
            // lower compression slope below knee one
            region_next = DRC_REG_LOWER;
            target_next = curve.knee1_out_level
                + slope_mul(rms_level - curve.knee1_in_level, curve.lower_slope);
            // gate region only with gate enabled
            if (curve.gate_enable && rms_level < curve.knee2_in_level)
            begin
                region_next = DRC_REG_GATE;
                // drop to knee two output, else continue from the lower curve
                target_next = (curve.knee2_drop_enable ? curve.knee2_out_level : knee2_curve)
                    + slope_mul(rms_level - curve.knee2_in_level, curve.gate_expansion_slope);
            end
        end
    end

    // floor follows the region registered with the target, so both stay in step
    // target minus measured, clamped by region floor and ceiling
    always_comb
    begin
        logic signed [`DRC_LVL_W+8:0] g;
        g = target_reg - rms_level;
        if (region_reg == DRC_REG_GATE && g < dyn.gate_floor_gain)
            g = dyn.gate_floor_gain;
        else if (region_reg != DRC_REG_GATE && g < dyn.floor_gain)
            g = dyn.floor_gain;
        if (g > dyn.ceiling_gain)
            g = dyn.ceiling_gain;
        gain_want = g;
    end

    // curve stage lags the level detector by one cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            target_reg <= `DRC_GAIN_RESET;
        else
            target_reg <= drc_lvl_t'(target_next);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            region_reg <= DRC_REG_UPPER;
        else
            region_reg <= region_next;
    end

    // pairing anti-clip with fast release is left to software; each only picks a rate
    // crest factor is peak minus rms in dB
    assign crest_high = dyn.fast_release_enable
        && ((peak_level - rms_level) > dyn.fast_release_threshold);

    // fast rise of peak shortens attack period
    assign rising_fast = dyn.anticlip_enable && (peak_level > prev_peak_reg);
    assign attack_eff = (rising_fast && dyn.attack_rate > `DRC_ANTICLIP_SHIFT)
        ? dyn.attack_rate - `DRC_RATE_W'(`DRC_ANTICLIP_SHIFT) : dyn.attack_rate;
    assign decay_eff = crest_high ? dyn.fast_release_rate : dyn.decay_rate;

    // previous peak is taken per sample, so a held level never counts as rising
    always_ff @(posedge clk)
    begin
        if (rst)
            prev_peak_reg <= `DRC_LVL_FLOOR;
        else if (in_valid)
            prev_peak_reg <= peak_level;
    end

    // one free-running count serves both rates, so a rate change acts at once
    // rate code n: one quarter-dB step every 2**(n+base) samples
    always_ff @(posedge clk)
    begin
        if (rst)
            rate_cnt_reg <= '0;
        else if (in_valid)
            rate_cnt_reg <= rate_cnt_reg + 16'h0001;
    end

    function automatic logic rate_tick(input logic [15:0] cnt, input logic [`DRC_RATE_W-1:0] code);
        int sh;
        logic [15:0] mask;
        sh = int'(code) + RATE_BASE_SHIFT;
        // codes past the counter width saturate at the slowest rate
        if (sh > 15)
            sh = 15;
        mask = 16'((32'h1 << sh) - 1);
        return (cnt & mask) == 16'h0000;
    endfunction

    assign step_attack = in_valid && rate_tick(rate_cnt_reg, attack_eff);
    assign step_decay = in_valid && rate_tick(rate_cnt_reg, decay_eff);

    // wide accumulator cannot wrap; the reported level and the applied gain are both cut to twelve bits
    // slew toward wanted gain
    always_ff @(posedge clk)
    begin
        if (rst)
            gain_acc_reg <= (`DRC_LVL_W+9)'($signed(`DRC_GAIN_RESET));
        else if (!drc_enable)
            gain_acc_reg <= (`DRC_LVL_W+9)'($signed(`DRC_GAIN_RESET));
        else if (gain_want < gain_acc_reg && step_attack)
            gain_acc_reg <= gain_acc_reg - (`DRC_LVL_W+9)'(1);
        else if (gain_want > gain_acc_reg && step_decay)
            gain_acc_reg <= gain_acc_reg + (`DRC_LVL_W+9)'(1);
    end

    // linear gain from quarter dB: 6 dB per shift, remainder by small table
    function automatic drc_samp_t apply_gain(input drc_samp_t s, input drc_lvl_t g);
        logic signed [`DRC_SAMP_W+16:0] p;
        logic signed [`DRC_LVL_W-1:0] q;
        logic [1:0] f;
        logic [7:0] m;
        int sh;
        q = g;
        sh = int'(q) / 24;
        if (int'(q) - sh*24 < 0)
            sh = sh - 1;
        f = 2'(((int'(q) - sh*24) * 4) / 24);
        case (f)
            2'h0: m = 8'h80;
            2'h1: m = 8'h98;
            2'h2: m = 8'hB5;
            2'h3: m = 8'hD7;
            default: m = 8'h80;
        endcase
        p = (s * $signed({1'b0, m})) >>> 7;
        p = (sh >= 0) ? p <<< sh : p >>> (-sh);
        if (p > $signed({1'b0, {(`DRC_SAMP_W-1){1'b1}}}))
            p = $signed({1'b0, {(`DRC_SAMP_W-1){1'b1}}});
        else if (p < -$signed({1'b0, {(`DRC_SAMP_W-1){1'b1}}}))
            p = -$signed({1'b0, {(`DRC_SAMP_W-1){1'b1}}});
        return drc_samp_t'(p);
    endfunction

    // one-cycle strobe delay matches the memory's registered read
    always_ff @(posedge clk)
    begin
        if (rst)
            samp_d_reg <= 1'b0;
        else
            samp_d_reg <= in_valid;
    end

    // output strobe two cycles after the input
    always_ff @(posedge clk)
    begin
        if (rst)
            out_valid <= 1'b0;
        else
            out_valid <= samp_d_reg;
    end

    // delayed audio path gives look-ahead to the gain
    always_ff @(posedge clk)
    begin
        if (rst)
            out_samp <= '0;
        else if (samp_d_reg)
        begin
            out_samp.left <= drc_enable ? apply_gain(delayed.left, drc_lvl_t'(gain_acc_reg)) : delayed.left;
            out_samp.right <= drc_enable ? apply_gain(delayed.right, drc_lvl_t'(gain_acc_reg)) : delayed.right;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            activity_detect <= 1'b0;
        else
            activity_detect <= (activity_use_peak ? peak_level : rms_level) > activity_threshold;
    end

    // crest status follows the rate choice
    always_ff @(posedge clk)
    begin
        if (rst)
            fast_release_active <= 1'b0;
        else
            fast_release_active <= crest_high;
    end

    // gain report, slewed value cut to level width
    always_ff @(posedge clk)
    begin
        if (rst)
            gain_level <= `DRC_GAIN_RESET;
        else
            gain_level <= drc_lvl_t'(gain_acc_reg);
    end
endmodule

// *** shared/drc_regs.svh ***
// constants for the dynamic range controller: widths, reset values, timing counts
// assumes levels in dB are signed fixed point, 1/4 dB per lsb
`ifndef DRC_REGS_SVH
`define DRC_REGS_SVH
`define DRC_LVL_W 12
`define DRC_SAMP_W 24
`define DRC_FRAC_BITS 2
`define DRC_SLOPE_FRAC 4
`define DRC_RATE_W 4
`define DRC_RMS_SHIFT 6
`define DRC_PEAK_SHIFT 4
`define DRC_ATK_RESET 4'h4
`define DRC_DCY_RESET 4'h2
`define DRC_FAST_RELEASE_RATE_RESET 4'h0
`define DRC_ANTICLIP_LAT 4
`define DRC_ANTICLIP_SHIFT 2
`define DRC_LVL_FLOOR 12'h980
`define DRC_GAIN_RESET 12'h000
`endif

// *** shared/drc_pkg.sv ***
// types shared by the dynamic range controller files
// assumes drc_regs.svh is on the include path
`include "drc_regs.svh"
package drc_pkg;
    typedef logic signed [`DRC_LVL_W-1:0] drc_lvl_t;
    typedef logic signed [`DRC_SAMP_W-1:0] drc_samp_t;

    typedef struct packed {
        drc_samp_t left;
        drc_samp_t right;
    } drc_stereo_s;

    typedef struct packed {
        drc_lvl_t knee1_in_level;
        drc_lvl_t knee1_out_level;
        drc_lvl_t knee2_in_level;
        drc_lvl_t knee2_out_level;
        logic [5:0] upper_slope;
        logic [5:0] lower_slope;
        logic [5:0] gate_expansion_slope;
        logic gate_enable;
        logic knee2_drop_enable;
    } drc_curve_s;

    typedef struct packed {
        drc_lvl_t floor_gain;
        drc_lvl_t gate_floor_gain;
        drc_lvl_t ceiling_gain;
        logic [`DRC_RATE_W-1:0] attack_rate;
        logic [`DRC_RATE_W-1:0] decay_rate;
        logic [`DRC_RATE_W-1:0] fast_release_rate;
        drc_lvl_t fast_release_threshold;
        logic fast_release_enable;
        logic anticlip_enable;
    } drc_dyn_s;

    typedef enum logic [1:0] {
        DRC_REG_UPPER = 2'b00,
        DRC_REG_LOWER = 2'b01,
        DRC_REG_GATE = 2'b10
    } drc_region_e;
endpackage

// *** verilog/drc_delay_mem.sv ***
// small delay line memory for the anti-clip look-ahead
// assumes one write and one read per sample strobe
`timescale 1ns/1ps
module drc_delay_mem
    import drc_pkg::*;
#(
    parameter int DEPTH = `DRC_ANTICLIP_LAT,
    parameter int WIDTH = 2*`DRC_SAMP_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // access
    input wire logic advance,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [$clog2(DEPTH)-1:0] ptr_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
            ptr_reg <= '0;
        else if (advance)
            ptr_reg <= (ptr_reg == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : ptr_reg + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (advance)
            mem[ptr_reg] <= wr_data;
    end

    // oldest entry is read before it is overwritten
    always_ff @(posedge clk)
    begin
        if (rst)
            rd_data <= '0;
        else if (advance)
            rd_data <= mem[ptr_reg];
    end
endmodule

// *** verilog/drc_level_det.sv ***
// level detector: log-domain peak and averaged rms level of one stereo frame
// assumes sample strobe at most once per clock
`timescale 1ns/1ps
module drc_level_det
    import drc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // samples
    input wire logic in_valid,
    input wire drc_stereo_s in_samp,
    // levels in quarter dB, 0 is full scale
    output drc_lvl_t peak_level,
    output drc_lvl_t rms_level
);
    logic [`DRC_SAMP_W-2:0] mag_l;
    logic [`DRC_SAMP_W-2:0] mag_r;
    logic [`DRC_SAMP_W-2:0] mag;
    logic [`DRC_SAMP_W+`DRC_RMS_SHIFT-1:0] pow_acc_reg;
    logic [`DRC_SAMP_W-2:0] peak_reg;

    // rough log2 in quarter dB: msb position times 6 dB plus next bit fraction
    function automatic drc_lvl_t to_db(input logic [`DRC_SAMP_W-2:0] v);
        int pos;
        logic [`DRC_LVL_W-1:0] db;
        pos = -1;
        for (int i = 0; i < `DRC_SAMP_W-1; i++)
            if (v[i])
                pos = i;
        if (pos < 0)
            db = `DRC_LVL_FLOOR;
        else
        begin
            db = `DRC_LVL_W'((pos - (`DRC_SAMP_W-2)) * 24);
            if (pos > 0 && v[pos-1])
                db = db + `DRC_LVL_W'(14);
        end
        return drc_lvl_t'(db);
    endfunction

    function automatic logic [`DRC_SAMP_W-2:0] absval(input drc_samp_t s);
        logic [`DRC_SAMP_W-1:0] a;
        a = s[`DRC_SAMP_W-1] ? -s : s;
        return a[`DRC_SAMP_W-1] ? {(`DRC_SAMP_W-1){1'b1}} : a[`DRC_SAMP_W-2:0];
    endfunction

    assign mag_l = absval(in_samp.left);
    assign mag_r = absval(in_samp.right);
    assign mag = (mag_l > mag_r) ? mag_l : mag_r;

    // peak: instant attack, slow exponential fall
    always_ff @(posedge clk)
    begin
        if (rst)
            peak_reg <= '0;
        else if (in_valid)
            peak_reg <= (mag > peak_reg) ? mag : peak_reg - (peak_reg >> `DRC_PEAK_SHIFT);
    end

    // magnitude average stands in for rms; avoids a squarer at the cost of ~1 dB
    always_ff @(posedge clk)
    begin
        if (rst)
            pow_acc_reg <= '0;
        else if (in_valid)
            pow_acc_reg <= pow_acc_reg - (pow_acc_reg >> `DRC_RMS_SHIFT)
                + {{(`DRC_RMS_SHIFT+1){1'b0}}, mag};
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            peak_level <= `DRC_LVL_FLOOR;
            rms_level <= `DRC_LVL_FLOOR;
        end
        else
        begin
            peak_level <= to_db(peak_reg);
            rms_level <= to_db(pow_acc_reg[`DRC_SAMP_W+`DRC_RMS_SHIFT-2:`DRC_RMS_SHIFT]);
        end
    end
endmodule

// *** testbench/drc_core_sva.sv ***
// port assertions for the dynamic range controller core
// assumes gain limits stay fixed and drc_enable is low only from reset
`timescale 1ns/1ps
module drc_core_sva
    import drc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // stream
    input wire logic in_valid,
    input wire logic out_valid,
    // configuration
    input wire logic drc_enable,
    input wire drc_dyn_s dyn,
    // status
    input wire drc_lvl_t gain_level,
    input wire logic fast_release_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_out_latency: assert property (in_valid |-> ##2 out_valid)
        else $error("no output strobe two cycles after an input strobe");
    a_out_cause: assert property (out_valid |-> $past(in_valid, 2))
        else $error("output strobe without an input strobe before it");
    a_out_pulse: assert property (out_valid |=> !out_valid)
        else $error("output strobe longer than one cycle");
    a_gain_ceiling: assert property ($signed(gain_level) <= $signed(dyn.ceiling_gain))
        else $error("gain above the ceiling");
    a_gain_floor: assert property ($signed(gain_level) >= $signed(dyn.floor_gain) ||
        $signed(gain_level) >= $signed(dyn.gate_floor_gain))
        else $error("gain below both floors");
    a_gain_slew: assert property (gain_level == $past(gain_level) ||
        gain_level == $past(gain_level) + 12'h001 || gain_level == $past(gain_level) - 12'h001)
        else $error("gain moved more than one step");
    a_gain_held_off: assert property (!drc_enable && $past(!drc_enable) |-> gain_level == 12'h000)
        else $error("gain not unity while bypassed");
    a_fast_idle: assert property ((!dyn.fast_release_enable) [*3] |-> !fast_release_active)
        else $error("fast release active while disabled");
endmodule

bind drc_core drc_core_sva drc_core_sva_inst (
    .clk(clk),
    .rst(rst),
    .in_valid(in_valid),
    .out_valid(out_valid),
    .drc_enable(drc_enable),
    .dyn(dyn),
    .gain_level(gain_level),
    .fast_release_active(fast_release_active)
);

// *** testbench/drc_src.sv ***
// sample source standing in for the audio interface feeding the controller
// assumes run stays low until reset has been released
`timescale 1ns/1ps
module drc_src
    import drc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic spike,
    input wire drc_samp_t amp,
    // stream
    output logic in_valid,
    output drc_stereo_s in_samp
);
    logic [7:0] count_reg = 8'h00;

    initial
    begin
        in_valid = 1'b0;
        in_samp = '0;
    end

    // one sample every fourth cycle, well inside the two cycle spacing
    always @(posedge clk)
    begin
        #1;
        in_valid = 1'b0;
        if (run && !rst && count_reg[1:0] == 2'b00)
        begin
            in_valid = 1'b1;
            in_samp.left = (spike && count_reg[5:2] == 4'h0) ? 24'h7FFFF0 : amp + drc_samp_t'(count_reg[7:2]);
            if (count_reg[2])
                in_samp.left = -in_samp.left;
            in_samp.right = in_samp.left ^ 24'h00000F;
        end
        else
            // idle lines toggle between the last sample and its inverse
            in_samp = ~in_samp;
        count_reg = rst ? 8'h00 : count_reg + 8'h01;
    end
endmodule

// *** testbench/dynamic_range_controller_bench.sv ***
// self-checking bench for the dynamic range controller core
// assumes the source model paces samples; rates are shortened to one step a sample
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module dynamic_range_controller_bench
    import drc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic spike = 1'b0;
    logic drc_enable = 1'b0;
    logic activity_use_peak = 1'b0;
    drc_samp_t amp = 24'h400000;
    drc_lvl_t activity_threshold = 12'hF60;
    logic in_valid;
    logic out_valid;
    logic activity_detect;
    logic fast_release_active;
    logic seen;
    drc_stereo_s in_samp;
    drc_stereo_s out_samp;
    drc_curve_s curve;
    drc_dyn_s dyn;
    drc_lvl_t gain_level;
    drc_stereo_s sent[$];
    int num_errors = 0;
    int tests_run = 0;

    always #10 clk = ~clk;

    drc_src drc_src_inst (.clk(clk), .rst(rst), .run(run), .spike(spike), .amp(amp), .in_valid(in_valid),
        .in_samp(in_samp));

    drc_core #(.RATE_BASE_SHIFT(0)) drc_core_inst (.clk(clk), .rst(rst), .in_valid(in_valid), .in_samp(in_samp),
        .out_valid(out_valid), .out_samp(out_samp), .drc_enable(drc_enable), .curve(curve), .dyn(dyn),
        .activity_use_peak(activity_use_peak), .activity_threshold(activity_threshold),
        .gain_level(gain_level), .activity_detect(activity_detect), .fast_release_active(fast_release_active));

    // bypassed output is the sample sent four samples earlier
    always @(posedge clk)
    begin
        if (!rst && in_valid)
            sent.push_back(in_samp);
        if (!rst && out_valid && !drc_enable && sent.size() > 4)
            `CHK(out_samp, sent[sent.size()-5])
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wait_samples(input int n);
        int got;
        got = 0;
        for (int k = 0; k < 16 * n && got < n; k++)
        begin
            @(posedge clk);
            if (in_valid === 1'b1)
                got++;
        end
        if (got < n)
        begin
            num_errors++;
            tally_and_finish();
        end
        #1;
    endtask

    task automatic check_activity(input logic expect_on);
        for (int p = 0; p < 2; p++)
        begin
            activity_use_peak = p[0];
            wait_samples(2);
            `CHK(activity_detect, expect_on)
        end
    endtask

    initial
    begin
        curve = '{knee1_in_level: 12'hFA0, knee1_out_level: 12'hFA0, knee2_in_level: 12'hF10,
            knee2_out_level: 12'hEC0, upper_slope: 6'h00, lower_slope: 6'h00, gate_expansion_slope: 6'h30,
            gate_enable: 1'b0, knee2_drop_enable: 1'b0};
        dyn = '{floor_gain: 12'hFD0, gate_floor_gain: 12'hF70, ceiling_gain: 12'h048, attack_rate: 4'h0,
            decay_rate: 4'h0, fast_release_rate: 4'h0, fast_release_threshold: 12'h018,
            fast_release_enable: 1'b0, anticlip_enable: 1'b0};
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK(gain_level, 12'h000)
        `CHK(activity_detect, 1'b0)
        // one path only, a single instance is fed
        run = 1'b1;
        wait_samples(40);
        `CHK(gain_level, 12'h000)
        $display("bypass test done");
        // anti-clip only while fast release is off
        dyn.anticlip_enable = 1'b1;
        drc_enable = 1'b1;
        wait_samples(600);
        `CHK(gain_level, 12'hFD0)
        check_activity(1'b1);
        $display("loud test done");
        dyn.anticlip_enable = 1'b0;
        amp = 24'h000800;
        wait_samples(600);
        `CHK(gain_level, 12'h048)
        check_activity(1'b0);
        $display("quiet test done");
        curve.gate_enable = 1'b1;
        curve.knee2_drop_enable = 1'b1;
        wait_samples(600);
        `CHK(gain_level, 12'hF80)
        // a deeper drop pushes the wanted gain below the gate floor
        curve.knee2_out_level = 12'hE80;
        wait_samples(100);
        `CHK(gain_level, 12'hF70)
        $display("gate test done");
        curve.gate_enable = 1'b0;
        curve.knee2_drop_enable = 1'b0;
        spike = 1'b1;
        dyn.fast_release_enable = 1'b1;
        seen = 1'b0;
        for (int i = 0; i < 1600 && seen !== 1'b1; i++)
        begin
            @(posedge clk);
            seen = fast_release_active;
        end
        `CHK(seen, 1'b1)
        if (seen !== 1'b1)
            tally_and_finish();
        #1;
        dyn.fast_release_enable = 1'b0;
        wait_samples(20);
        `CHK(fast_release_active, 1'b0)
        // spikes keep the peak high while the average stays low
        activity_threshold = 12'hFD0;
        activity_use_peak = 1'b1;
        wait_samples(2);
        `CHK(activity_detect, 1'b1)
        activity_use_peak = 1'b0;
        wait_samples(2);
        `CHK(activity_detect, 1'b0)
        $display("fast release test done");
        tally_and_finish();
    end
endmodule
